//--- rtl/hbridge_drive_fault_control.sv
`timescale 1ns/1ps
// Function
// - Shorts, overcurrent, heat, undervoltage force tristate
// - Short, overcurrent and overtemperature faults stay latched
// - Inhibit fall or permit rise clears latch
// - Undervoltage releases itself when supply returns
// - Current limit: timed off interval, then restart
// - Current limit keeps flag high, no latch
// - Free-wheel: parallel low side on negative output
// - Free-wheel conduction ends on positive output
// - Fault flag low whenever bridge forced off, except by current limit
// - Mode pin picks flag or serial reporting
// - Serial port is slave; master drives clock
// - Serial output tristate while deselected
// - First two bits carry device address
// - Output on rising, input on falling edge
// - Commit frame on deselect after sixteen clocks
// - Address mismatch: ignore frame, output tristate
module hbridge_drive_fault_control #(
    parameter int unsigned CLIMIT_OFF_NS = 20000,
    parameter logic [7:0] IDENT_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] VERSION_CODE = 8'h01 // Arbitrary value
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic bridge_inhibit,
    input wire logic bridge_permit,
    input wire logic phase_a_cmd,
    input wire logic phase_b_cmd,
    input wire logic diag_mode_select,
    input wire logic clock_or_flag_in,
    output logic clock_or_flag_out,
    output logic clock_or_flag_oe,
    input wire logic slave_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic short_detect,
    input wire logic overcurrent_detect,
    input wire logic overtemp_detect,
    input wire logic undervoltage_detect,
    input wire logic current_limit_detect,
    input wire logic out_a_negative,
    input wire logic out_b_negative,
    output logic half_bridge_a_out,
    output logic half_bridge_a_oe,
    output logic half_bridge_b_out,
    output logic half_bridge_b_oe,
    output logic freewheel_a_low_on,
    output logic freewheel_b_low_on,
    output logic fault_flag_out,
    output logic [15:0] rx_frame,
    output logic rx_frame_stb
);
    localparam int unsigned CLIM_RAW = CLIMIT_OFF_NS * hbridge_pkg::CLOCK_MHZ
        / hbridge_pkg::NS_PER_US;
    localparam int unsigned CLIM_CYCLES = (CLIM_RAW < 1) ? 1 : CLIM_RAW;
    localparam int CLIM_W = $clog2(CLIM_CYCLES + 1);
    localparam logic [CLIM_W-1:0] CLIM_LAST = CLIM_W'(CLIM_CYCLES - 1);
    localparam int unsigned FB = hbridge_pkg::FRAME_BITS;
    localparam int unsigned BB = hbridge_pkg::BYTE_BITS;

    // ==========================================================
    // Pin capture
    hbridge_pkg::pins_t raw_pins;
    hbridge_pkg::pins_t pin;
    hbridge_pkg::pins_t prev_q;
    logic [$bits(hbridge_pkg::pins_t)-1:0] pin_vec;

    // An open inhibit pulls high and an open permit pulls low,
    // so a floating gating pin resolves to the off state here.
    assign raw_pins = '{
        inhibit: bridge_inhibit,
        permit: bridge_permit,
        phase_a: phase_a_cmd,
        phase_b: phase_b_cmd,
        mode_spi: diag_mode_select,
        spi_clk: clock_or_flag_in,
        select_n: slave_select_n,
        spi_in: serial_in,
        short_det: short_detect,
        overcurrent: overcurrent_detect,
        overtemp: overtemp_detect,
        undervoltage: undervoltage_detect,
        current_limit: current_limit_detect,
        a_negative: out_a_negative,
        b_negative: out_b_negative
    };

    pin_sync #(
        .WIDTH($bits(hbridge_pkg::pins_t)),
        .INIT(hbridge_pkg::PIN_RESET)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .async_in(raw_pins),
        .stable_out(pin_vec)
    );

    assign pin = hbridge_pkg::pins_t'(pin_vec);

    always_ff @(posedge clock) begin
        if (rst) begin
            prev_q <= hbridge_pkg::PIN_RESET;
        end else begin
            prev_q <= pin;
        end
    end

    logic inhibit_fall;
    logic permit_rise;
    logic sck_rise;
    logic sck_fall;
    assign inhibit_fall = prev_q.inhibit & ~pin.inhibit;
    assign permit_rise = ~prev_q.permit & pin.permit;
    assign sck_rise = ~prev_q.spi_clk & pin.spi_clk;
    assign sck_fall = prev_q.spi_clk & ~pin.spi_clk;

    // ==========================================================
    // Bridge control and fault handling
    logic gate_ok;
    logic hard_fault;
    logic latched_q;
    logic latched_d;
    logic ilim_q;
    logic ilim_d;
    logic [CLIM_W-1:0] ilim_cnt_q;
    logic [CLIM_W-1:0] ilim_cnt_d;
    logic on_d;
    logic flag_d;
    hbridge_pkg::bridge_t bridge_q;
    hbridge_pkg::bridge_t bridge_d;
    logic flag_q;
    logic pin_oe_q;
    logic pin_oe_d;

    assign gate_ok = ~pin.inhibit & pin.permit & ~pin.undervoltage;
    assign hard_fault = pin.short_det | pin.overcurrent | pin.overtemp;

    always_comb begin
        // A fault arriving with the clearing edge wins
        latched_d = hard_fault | (latched_q & ~(inhibit_fall | permit_rise));
        ilim_d = ilim_q;
        ilim_cnt_d = ilim_cnt_q;
        if (!gate_ok || latched_d) begin
            ilim_d = 1'b0;
            ilim_cnt_d = '0;
        end else if (ilim_q) begin
            if (ilim_cnt_q == CLIM_LAST) begin
                ilim_d = 1'b0;
                ilim_cnt_d = '0;
            end else begin
                ilim_cnt_d = ilim_cnt_q + 1'b1;
            end
        end else if (pin.current_limit) begin
            ilim_d = 1'b1;
            ilim_cnt_d = '0;
        end
        on_d = gate_ok & ~latched_d & ~ilim_d;
        flag_d = gate_ok & ~latched_d;
        bridge_d.a_oe = on_d;
        bridge_d.b_oe = on_d;
        bridge_d.a_level = pin.phase_a;
        bridge_d.b_level = pin.phase_b;
        // Parallel low side only while both sides are off
        bridge_d.fw_a = ~on_d & pin.a_negative;
        bridge_d.fw_b = ~on_d & pin.b_negative;
        pin_oe_d = ~pin.mode_spi;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            latched_q <= 1'b0;
            ilim_q <= 1'b0;
            ilim_cnt_q <= '0;
            bridge_q <= '0;
            flag_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            latched_q <= latched_d;
            ilim_q <= ilim_d;
            ilim_cnt_q <= ilim_cnt_d;
            bridge_q <= bridge_d;
            flag_q <= flag_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign half_bridge_a_out = bridge_q.a_level;
    assign half_bridge_a_oe = bridge_q.a_oe;
    assign half_bridge_b_out = bridge_q.b_level;
    assign half_bridge_b_oe = bridge_q.b_oe;
    assign freewheel_a_low_on = bridge_q.fw_a;
    assign freewheel_b_low_on = bridge_q.fw_b;
    assign fault_flag_out = flag_q;
    assign clock_or_flag_out = flag_q;
    assign clock_or_flag_oe = pin_oe_q;

    // ==========================================================
    // Serial slave
    function automatic logic instr_known(input logic [BB-1:0] ib);
        logic [hbridge_pkg::INSTR_BITS-1:0] code;
        code = ib[hbridge_pkg::INSTR_HI:hbridge_pkg::INSTR_LO];
        instr_known = (code == hbridge_pkg::INSTR_READ_IDENT)
            || (code == hbridge_pkg::INSTR_READ_VERSION)
            || (code == hbridge_pkg::INSTR_READ_DIAG);
    endfunction

    function automatic logic [BB-1:0] reply_byte(input logic [BB-1:0] ib,
                                                 input logic [BB-1:0] status);
        logic [hbridge_pkg::INSTR_BITS-1:0] code;
        code = ib[hbridge_pkg::INSTR_HI:hbridge_pkg::INSTR_LO];
        case (code)
            hbridge_pkg::INSTR_READ_IDENT: reply_byte = IDENT_CODE;
            hbridge_pkg::INSTR_READ_VERSION: reply_byte = VERSION_CODE;
            hbridge_pkg::INSTR_READ_DIAG: reply_byte = status;
            default: reply_byte = hbridge_pkg::UNUSED_DATA;
        endcase
    endfunction

    hbridge_pkg::spi_state_t state_q;
    hbridge_pkg::spi_state_t state_d;
    logic [hbridge_pkg::CNT_BITS-1:0] cnt_q;
    logic [hbridge_pkg::CNT_BITS-1:0] cnt_d;
    logic [FB-1:0] rx_q;
    logic [FB-1:0] rx_d;
    logic [FB-1:0] tx_q;
    logic [FB-1:0] tx_d;
    logic so_q;
    logic so_d;
    logic so_oe_q;
    logic so_oe_d;
    logic error_q;
    logic error_d;
    logic [FB-1:0] frame_q;
    logic [FB-1:0] frame_d;
    logic stb_q;
    logic stb_d;
    logic [BB-1:0] status_byte;

    assign status_byte = {pin.inhibit, pin.undervoltage, pin.overtemp, ilim_q,
                          pin.short_det, pin.overcurrent, latched_q, ~flag_q};

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        so_d = so_q;
        so_oe_d = so_oe_q;
        error_d = error_q;
        frame_d = frame_q;
        stb_d = 1'b0;
        if (!pin.mode_spi) begin
            // Flag mode holds the serial side in its default state
            state_d = hbridge_pkg::st_wait;
            cnt_d = '0;
            so_oe_d = 1'b0;
            error_d = 1'b0;
        end else begin
            case (state_q)
                hbridge_pkg::st_wait: begin
                    so_oe_d = 1'b0;
                    if (!pin.select_n) begin
                        state_d = hbridge_pkg::st_frame;
                        cnt_d = '0;
                        tx_d = {hbridge_pkg::ADDR_FILL, hbridge_pkg::CHECK_PATTERN,
                                error_q, hbridge_pkg::DATA_IDLE};
                    end
                end
                hbridge_pkg::st_frame, hbridge_pkg::st_ignore: begin
                    if (pin.select_n) begin
                        state_d = hbridge_pkg::st_wait;
                        so_oe_d = 1'b0;
                        if (state_q == hbridge_pkg::st_frame) begin
                            // Commit only on exactly sixteen clocks
                            error_d = (cnt_q != hbridge_pkg::FRAME_CLOCKS)
                                || !instr_known(rx_q[FB-1 -: BB]);
                            if (!error_d) begin
                                frame_d = rx_q;
                                stb_d = 1'b1;
                            end
                        end
                    end else begin
                        if (sck_fall) begin
                            rx_d = {rx_q[FB-2:0], pin.spi_in};
                            if (cnt_q != hbridge_pkg::CNT_MAX) begin
                                cnt_d = cnt_q + 1'b1;
                            end
                            if (cnt_d == hbridge_pkg::ADDR_CLOCKS
                                && rx_d[hbridge_pkg::ADDR_BITS-1:0]
                                   != hbridge_pkg::OWN_ADDRESS) begin
                                state_d = hbridge_pkg::st_ignore;
                            end
                            if (cnt_d == hbridge_pkg::INSTR_CLOCKS) begin
                                tx_d[FB-1 -: BB] = reply_byte(rx_d[BB-1:0], status_byte);
                            end
                        end
                        if (sck_rise && state_q == hbridge_pkg::st_frame) begin
                            so_d = tx_q[FB-1];
                            tx_d = {tx_q[FB-2:0], 1'b0};
                            // Address bits go out as tristate
                            so_oe_d = (cnt_q >= hbridge_pkg::ADDR_CLOCKS);
                        end
                        if (state_d == hbridge_pkg::st_ignore) begin
                            so_oe_d = 1'b0;
                        end
                    end
                end
                default: begin
                    state_d = hbridge_pkg::st_wait;
                    so_oe_d = 1'b0;
                end
            endcase
        end
    end

    // The clock pin is only sampled in serial mode; this end drives it only in flag mode
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= hbridge_pkg::st_wait;
            cnt_q <= '0;
            rx_q <= '0;
            tx_q <= '0;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
            error_q <= 1'b0;
            frame_q <= '0;
            stb_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            so_q <= so_d;
            so_oe_q <= so_oe_d;
            error_q <= error_d;
            frame_q <= frame_d;
            stb_q <= stb_d;
        end
    end

    assign serial_out = so_q;
    assign serial_out_oe = so_oe_q;
    assign rx_frame = frame_q;
    assign rx_frame_stb = stb_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_phase_map;
        half_bridge_a_oe |-> half_bridge_a_out == $past(pin.phase_a)
            && half_bridge_b_out == $past(pin.phase_b) && half_bridge_b_oe;
    endproperty
    a_phase_map: assert property (p_phase_map)
        else $error("bridge outputs do not follow phase inputs");

    property p_gate_off;
        (pin.inhibit || !pin.permit) |=> !half_bridge_a_oe && !half_bridge_b_oe
            && !fault_flag_out;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("bridge active while gated off");

    property p_fault_off;
        (hard_fault || pin.undervoltage) |=> !half_bridge_a_oe && !fault_flag_out;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("bridge active during fault");

    property p_latch_hold;
        latched_q && !inhibit_fall && !permit_rise |=> latched_q && !fault_flag_out;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched fault released without clearing edge");

    property p_latch_clear;
        latched_q && !hard_fault && (inhibit_fall || permit_rise) |=> !latched_q;
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("latched fault not cleared by edge");

    property p_self_release;
        gate_ok && !hard_fault && !latched_q |=> fault_flag_out;
    endproperty
    a_self_release: assert property (p_self_release)
        else $error("flag low although no fault remains");

    property p_limit_restart;
        ilim_q && ilim_cnt_q == CLIM_LAST && gate_ok && !hard_fault
            |=> !ilim_q && half_bridge_a_oe;
    endproperty
    a_limit_restart: assert property (p_limit_restart)
        else $error("bridge not restarted after limit interval");

    property p_limit_flag;
        ilim_q |-> fault_flag_out && !half_bridge_a_oe && !latched_q;
    endproperty
    a_limit_flag: assert property (p_limit_flag)
        else $error("current limit disturbed the flag");

    property p_freewheel;
        !on_d && pin.a_negative |=> freewheel_a_low_on && !half_bridge_a_oe;
    endproperty
    a_freewheel: assert property (p_freewheel)
        else $error("free-wheel transistor not switched on");

    property p_freewheel_end;
        !pin.b_negative |=> !freewheel_b_low_on;
    endproperty
    a_freewheel_end: assert property (p_freewheel_end)
        else $error("free-wheel conduction outlasts negative level");

    // Pin drives the flag one cycle after flag mode is seen, and only then
    property p_mode_pin;
        1'b1 |=> clock_or_flag_oe != $past(pin.mode_spi);
    endproperty
    a_mode_pin: assert property (p_mode_pin)
        else $error("shared pin serves the wrong mode");

    property p_deselect_z;
        pin.select_n |=> !serial_out_oe;
    endproperty
    a_deselect_z: assert property (p_deselect_z)
        else $error("serial output driven while deselected");

    property p_out_edge;
        $changed(serial_out) |-> $past(sck_rise);
    endproperty
    a_out_edge: assert property (p_out_edge)
        else $error("serial output changed off the rising edge");

    property p_commit;
        rx_frame_stb |-> $past(cnt_q) == hbridge_pkg::FRAME_CLOCKS
            && $past(state_q) == hbridge_pkg::st_frame && $past(pin.select_n);
    endproperty
    a_commit: assert property (p_commit)
        else $error("frame committed without sixteen clocks");

    property p_mismatch_z;
        state_q == hbridge_pkg::st_ignore |-> !serial_out_oe && !rx_frame_stb;
    endproperty
    a_mismatch_z: assert property (p_mismatch_z)
        else $error("foreign frame answered");

    c_commit: cover property (rx_frame_stb);
    c_limit: cover property ($rose(ilim_q) ##[1:8] ilim_q);
    c_clear: cover property ($fell(latched_q));
    c_ignore: cover property (state_q == hbridge_pkg::st_ignore);

endmodule

//--- rtl/hbridge_pkg.sv
package hbridge_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLOCK_MHZ = 200;
    localparam int unsigned NS_PER_US = 1000;

    // ==========================================================
    // Serial frame layout
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned ADDR_BITS = 2;
    localparam int unsigned CNT_BITS = 5;
    localparam logic [CNT_BITS-1:0] ADDR_CLOCKS = 5'h02;
    localparam logic [CNT_BITS-1:0] INSTR_CLOCKS = 5'h08;
    localparam logic [CNT_BITS-1:0] FRAME_CLOCKS = 5'h10;
    localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h1f;
    localparam logic [ADDR_BITS-1:0] OWN_ADDRESS = 2'h0;
    localparam logic [ADDR_BITS-1:0] ADDR_FILL = 2'h0;
    localparam int unsigned INSTR_HI = 5;
    localparam int unsigned INSTR_LO = 1;
    localparam int unsigned INSTR_BITS = 5;

    // ==========================================================
    // Instruction codes and check byte
    localparam logic [INSTR_BITS-1:0] INSTR_READ_IDENT = 5'h00;
    localparam logic [INSTR_BITS-1:0] INSTR_READ_VERSION = 5'h01;
    localparam logic [INSTR_BITS-1:0] INSTR_READ_DIAG = 5'h04;
    localparam logic [4:0] CHECK_PATTERN = 5'h15;
    localparam logic [BYTE_BITS-1:0] UNUSED_DATA = 8'hff;
    localparam logic [BYTE_BITS-1:0] DATA_IDLE = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        st_wait,
        st_frame,
        st_ignore
    } spi_state_t;

    typedef struct packed {
        logic inhibit;
        logic permit;
        logic phase_a;
        logic phase_b;
        logic mode_spi;
        logic spi_clk;
        logic select_n;
        logic spi_in;
        logic short_det;
        logic overcurrent;
        logic overtemp;
        logic undervoltage;
        logic current_limit;
        logic a_negative;
        logic b_negative;
    } pins_t;

    // Safe idle: bridge inhibited, not permitted, slave deselected
    localparam pins_t PIN_RESET = '{inhibit: 1'b1, select_n: 1'b1, default: 1'b0};

    typedef struct packed {
        logic a_oe;
        logic a_level;
        logic b_oe;
        logic b_level;
        logic fw_a;
        logic fw_b;
    } bridge_t;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] stable_d;

    // A bit counts as changed only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            stable_q <= INIT;
        end else begin
            meta_q <= async_in;
            s2_q <= meta_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    assign stable_out = stable_q;

endmodule

//--- test/spi_master_model.sv
`timescale 1ns/1ps
// ==========================================================
// Serial master standing in for the microcontroller
module spi_master_model (
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b1;
    end

    // Data changes while the clock is low, so the slave's falling-edge sample sees it settled
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'hffff;
        ss_n = 1'b0;
        #60;
        for (int i = 0; i < n; i++) begin
            mosi = tx[15-i];
            #4 sck = 1'b1;
            #24 sck = 1'b0;
            #20 rx[15-i] = miso_oe ? miso : 1'bz;
        end
        #40 ss_n = 1'b1;
        // Released data line must not keep showing the last bit
        mosi = ~mosi;
        #100;
    endtask
endmodule

//--- test/tb_hbridge_drive_fault_control.sv
`timescale 1ns/1ps
module tb_hbridge_drive_fault_control;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary value
    localparam logic [7:0] VER = 8'h07; // Arbitrary value
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic inh = 1'b1, prm = 1'b0, pa = 1'b0, pb = 1'b0, mode = 1'b0;
    logic sc = 1'b0, oc = 1'b0, ot = 1'b0, uv = 1'b0, cl = 1'b0, an = 1'b0, bn = 1'b0;
    logic sck, ss_n, mosi, cf_out, cf_oe, so, so_oe, stb;
    logic a_out, a_oe, b_out, b_oe, fw_a, fw_b, flag;
    logic [15:0] rx_frame, rx;
    int n_errors = 0;
    int total_checks = 0;
    int n_stb = 0;

    always #2.5 clock = ~clock;
    // Counted away from the launching edge so the pulse is seen exactly once
    always @(negedge clock) begin
        if (stb === 1'b1) n_stb++;
    end

    hbridge_drive_fault_control #(.CLIMIT_OFF_NS(50), .IDENT_CODE(ID), .VERSION_CODE(VER))
        hbridge_drive_fault_control_i (
        .clock(clock), .rst(rst), .bridge_inhibit(inh), .bridge_permit(prm),
        .phase_a_cmd(pa), .phase_b_cmd(pb), .diag_mode_select(mode),
        .clock_or_flag_in(cf_oe ? cf_out : sck), .clock_or_flag_out(cf_out),
        .clock_or_flag_oe(cf_oe), .slave_select_n(ss_n), .serial_in(mosi),
        .serial_out(so), .serial_out_oe(so_oe), .short_detect(sc),
        .overcurrent_detect(oc), .overtemp_detect(ot), .undervoltage_detect(uv),
        .current_limit_detect(cl), .out_a_negative(an), .out_b_negative(bn),
        .half_bridge_a_out(a_out), .half_bridge_a_oe(a_oe), .half_bridge_b_out(b_out),
        .half_bridge_b_oe(b_oe), .freewheel_a_low_on(fw_a), .freewheel_b_low_on(fw_b),
        .fault_flag_out(flag), .rx_frame(rx_frame), .rx_frame_stb(stb)
    );

    spi_master_model spi_master_model_i (
        .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(so), .miso_oe(so_oe)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Stage word: a_oe, b_oe, flag, fw_a, fw_b
    function automatic logic [15:0] st();
        return {11'h000, a_oe, b_oe, flag, fw_a, fw_b};
    endfunction

    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_bridge();
        for (int i = 0; i < 4; i++) begin
            {pa, pb} = 2'(i);
            cyc(8);
            chk(st(), 16'h001c);
            chk({14'h0000, a_out, b_out}, {14'h0000, pa, pb});
            chk({15'h0000, cf_out}, 16'h0001);
        end
        inh = 1'b1;
        cyc(8);
        chk(st(), 16'h0000);
        inh = 1'b0;
        prm = 1'b0;
        cyc(8);
        chk(st(), 16'h0000);
        prm = 1'b1;
        cyc(8);
    endtask

    task automatic t_faults();
        for (int k = 0; k < 3; k++) begin
            {sc, oc, ot} = 3'h1 << k;
            cyc(8);
            chk(st(), 16'h0000);
            {sc, oc, ot} = 3'h0;
            cyc(8);
            chk(st(), 16'h0000);
            if (k == 1) prm = 1'b0;
            else inh = 1'b1;
            cyc(8);
            inh = 1'b0;
            prm = 1'b1;
            cyc(8);
            chk(st(), 16'h001c);
        end
        uv = 1'b1;
        cyc(8);
        chk(st(), 16'h0000);
        uv = 1'b0;
        cyc(8);
        chk(st(), 16'h001c);
        cl = 1'b1;
        cyc(5);
        cl = 1'b0;
        cyc(7);
        chk(st(), 16'h0004);
        cyc(10);
        chk(st(), 16'h001c);
        inh = 1'b1;
        an = 1'b1;
        cyc(8);
        chk(st(), 16'h0002);
        an = 1'b0;
        bn = 1'b1;
        cyc(8);
        chk(st(), 16'h0001);
        bn = 1'b0;
        cyc(8);
        chk(st(), 16'h0000);
    endtask

    task automatic t_serial();
        chk({15'h0000, cf_oe}, {15'h0000, 1'b1});
        chk({15'h0000, cf_out}, 16'h0000);
        mode = 1'b1;
        cyc(8);
        chk({14'h0000, cf_oe, so_oe}, 16'h0000);
        spi_master_model_i.xfer(16'h0000, 16, rx);
        chk(rx, {2'hz, 6'h2a, ID});
        chk(rx_frame, 16'h0000);
        chk(16'(n_stb), 16'h0001);
        spi_master_model_i.xfer(16'h4000, 16, rx);
        chk(rx, 16'hzzzz);
        spi_master_model_i.xfer(16'h0200, 8, rx);
        chk(16'(n_stb), 16'h0001);
        spi_master_model_i.xfer(16'h0200, 16, rx);
        chk(rx, {2'hz, 6'h2b, VER});
        chk(16'(n_stb), 16'h0002);
        chk(rx_frame, 16'h0200);
        // Status reply: inhibit high and flag low, nothing else pending
        spi_master_model_i.xfer(16'h0800, 16, rx);
        chk(rx, {2'hz, 6'h2a, 8'h81});
        // Unused code answers ff and marks the next check byte
        spi_master_model_i.xfer(16'h3e00, 16, rx);
        chk(rx, {2'hz, 6'h2a, 8'hff});
        spi_master_model_i.xfer(16'h0000, 16, rx);
        chk(rx, {2'hz, 6'h2b, ID});
        chk(16'(n_stb), 16'h0004);
        chk(rx_frame, 16'h0000);
        chk({15'h0000, so_oe}, 16'h0000);
    endtask

    initial begin
        cyc(3);
        chk(st(), 16'h0000);
        rst = 1'b0;
        inh = 1'b0;
        prm = 1'b1;
        cyc(8);
        t_bridge();
        t_faults();
        t_serial();
        print_verdict();
    end

    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule
